// [hw/bbu_pkg.sv]
// Package for the branch and bit instruction unit.
// Assumes a single AHB-Lite slave port with 32-bit aligned word registers.
package bbu_pkg;

    // Register byte offsets.
    localparam logic [7:0] BBU_CTRL_OFF    = 8'h00;
    localparam logic [7:0] BBU_OPERAND_OFF = 8'h04;
    localparam logic [7:0] BBU_PC_OFF      = 8'h08;
    localparam logic [7:0] BBU_POINTER_OFF = 8'h0C;
    localparam logic [7:0] BBU_OFFSET_OFF  = 8'h10;
    localparam logic [7:0] BBU_FLAGS_OFF   = 8'h14;
    localparam logic [7:0] BBU_RESULT_OFF  = 8'h18;
    localparam logic [7:0] BBU_RETURN_OFF  = 8'h1C;

    // Values after reset.
    localparam logic [15:0] BBU_PC_RST    = 16'h0000;
    localparam logic [7:0]  BBU_FLAGS_RST = 8'h00;

    // Positions of the flags inside status_flag_register.
    localparam logic [2:0] BBU_FLAG_C = 3'h0;
    localparam logic [2:0] BBU_FLAG_Z = 3'h1;
    localparam logic [2:0] BBU_FLAG_N = 3'h2;
    localparam logic [2:0] BBU_FLAG_V = 3'h3;
    localparam logic [2:0] BBU_FLAG_S = 3'h4;
    localparam logic [2:0] BBU_FLAG_H = 3'h5;
    localparam logic [2:0] BBU_FLAG_T = 3'h6;
    localparam logic [2:0] BBU_FLAG_I = 3'h7;

    // Cycle counts of each instruction class.
    localparam logic [2:0] BBU_CYC_ONE      = 3'h1;
    localparam logic [2:0] BBU_CYC_PJUMP    = 3'h2;
    localparam logic [2:0] BBU_CYC_PCALL    = 3'h3;
    localparam logic [2:0] BBU_CYC_BR_TAKEN = 3'h2;
    localparam logic [2:0] BBU_CYC_SKIP1    = 3'h2;
    localparam logic [2:0] BBU_CYC_SKIP2    = 3'h3;
    localparam logic [2:0] BBU_CYC_IOBIT    = 3'h2;

    // Program counter advances.
    localparam logic [15:0] BBU_PC_STEP  = 16'h0001;
    localparam logic [15:0] BBU_PC_SKIP1 = 16'h0002;
    localparam logic [15:0] BBU_PC_SKIP2 = 16'h0003;

    typedef enum logic [4:0] {
        pointer_jump,
        pointer_call,
        compare_skip_equal,
        compare_immediate,
        skip_reg_bit_clear,
        skip_reg_bit_set,
        skip_io_bit_clear,
        skip_io_bit_set,
        branch_flag_set,
        branch_flag_clear,
        branch_signed_ge,
        branch_signed_lt,
        branch_halfcarry_set,
        branch_halfcarry_clear,
        branch_overflow_set,
        branch_overflow_clear,
        branch_irq_enabled,
        branch_irq_disabled,
        io_bit_set,
        io_bit_clear,
        rotate_left_carry,
        rotate_right_carry,
        bit_to_transfer_flag,
        transfer_flag_to_bit,
        halfcarry_flag_set,
        halfcarry_flag_clear,
        flag_set,
        flag_clear
    } bbu_op_type;

    // Layout of the control word; go starts an instruction.
    typedef struct packed {
        logic        go;
        logic [17:0] rsv_hi;
        logic        two_word;
        logic        rsv_mid;
        logic [2:0]  bit_sel;
        logic [2:0]  rsv_lo;
        logic [4:0]  op;
    } bbu_ctrl_type;

    // Layout of the operand word.
    typedef struct packed {
        logic [7:0] imm;
        logic [7:0] io_val;
        logic [7:0] rr_val;
        logic [7:0] rd_val;
    } bbu_operand_type;

    // Layout of the result word.
    typedef struct packed {
        logic [11:0] rsv;
        logic [2:0]  cycles;
        logic        busy;
        logic [7:0]  io_val;
        logic [7:0]  rd_val;
    } bbu_result_type;

endpackage : bbu_pkg

// [hw/bbu_unit.sv]
// Branch, skip, compare and bit instruction unit behind an AHB-Lite slave.
// Assumes one master, single word transfers, and a caller that polls busy.
//
// Behaviour
// RULE1: Pointer jump loads PC from pointer pair, two cycles, flags kept.
// RULE2: Pointer call loads PC from pointer pair, three cycles, flags kept.
// RULE3: Compare-skip-equal skips when registers match, 1/2/3 cycles.
// RULE4: Compare immediate subtracts constant, sets Z N V C H, one cycle.
// RULE5: Skip when selected register bit is zero, 1/2/3 cycles.
// RULE6: Skip when selected register bit is one, 1/2/3 cycles.
// RULE7: Skip when selected I/O bit is zero, 1/2/3 cycles.
// RULE8: Skip when selected I/O bit is one, 1/2/3 cycles.
// RULE9: Branch when selected flag is one, PC plus offset plus one.
// RULE10: Branch when selected flag is zero, one or two cycles.
// RULE11: Signed greater-or-equal branch taken when N xor V is zero.
// RULE12: Signed less-than branch taken when N xor V is one.
// RULE13: Half-carry branches test H set or clear, one or two cycles.
// RULE14: Overflow branches test V set or clear, one or two cycles.
// RULE15: Interrupt branches test I set or clear, one or two cycles.
// RULE16: I/O bit set forces the bit to one in two cycles.
// RULE17: I/O bit clear forces the bit to zero in two cycles.
// RULE18: Rotate left through carry, updates Z C N V, one cycle.
// RULE19: Rotate right through carry, updates Z C N V, one cycle.
// RULE20: Bit store copies register bit into T, changes only T.
// RULE21: Bit load copies T into register bit, flags kept.
// RULE22: Single flag set or clear writes only that flag, one cycle.
// RULE23: Skip costs two or three cycles by skipped length, else one.
// RULE24: Branch offset is sign-extended before adding with one.
`timescale 1ns/10ps
module bbu_unit #(
    parameter int OFFSET_W = 7
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp
);

    ////////////////////////////////////////////////////////////////////////
    // Bus slave.

    logic                     wr_pend;
    logic [7:0]               wr_addr;
    logic                     rd_take;
    logic [31:0]              next_rdata;
    logic                     start;
    logic                     busy;
    logic [2:0]               cnt;
    logic [2:0]               cycles;
    bbu_pkg::bbu_ctrl_type    cmd;
    bbu_pkg::bbu_operand_type opr;
    logic [15:0]              pc;
    logic [15:0]              ptr;
    logic [OFFSET_W-1:0]      offs;
    logic [7:0]               status_flag_register;
    logic [7:0]               rd_res;
    logic [7:0]               io_res;
    logic [15:0]              ret_addr;
    bbu_pkg::bbu_result_type  res_word;
    logic                     wr_ok;

    assign rd_take = hsel && hready && htrans[1] && !hwrite;
    assign wr_ok   = wr_pend && !busy;
    assign start   = wr_ok && wr_addr == bbu_pkg::BBU_CTRL_OFF && hwdata[31];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else if (hready) begin
            wr_pend <= hsel && htrans[1] && hwrite;
            wr_addr <= {haddr[7:2], 2'b00};
        end
    end

    always_comb begin
        res_word        = '0;
        res_word.rd_val = rd_res;
        res_word.io_val = io_res;
        res_word.busy   = busy;
        res_word.cycles = cycles;
        case ({haddr[7:2], 2'b00})
            bbu_pkg::BBU_CTRL_OFF:    next_rdata = 32'(cmd) & 32'h00001F1F;
            bbu_pkg::BBU_OPERAND_OFF: next_rdata = opr;
            bbu_pkg::BBU_PC_OFF:      next_rdata = {16'h0000, pc};
            bbu_pkg::BBU_POINTER_OFF: next_rdata = {16'h0000, ptr};
            bbu_pkg::BBU_OFFSET_OFF:  next_rdata = 32'(offs);
            bbu_pkg::BBU_FLAGS_OFF:   next_rdata = {24'h000000, status_flag_register};
            bbu_pkg::BBU_RESULT_OFF:  next_rdata = res_word;
            bbu_pkg::BBU_RETURN_OFF:  next_rdata = {16'h0000, ret_addr};
            default:                  next_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (rd_take) begin
                hrdata <= next_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Instruction evaluation.

    bbu_pkg::bbu_op_type op;
    logic [2:0]          need;
    logic [15:0]         next_pc;
    logic [7:0]          next_status_flag_register;
    logic [7:0]          next_rd;
    logic [7:0]          next_io;
    logic                cond;
    logic                sel_flag;
    logic                rd_bit;
    logic                io_bit;
    logic [7:0]          diff;
    logic [7:0]          rot;
    logic [7:0]          bit_mask;
    logic [15:0]         br_target;
    logic [15:0]         skip_step;
    logic [2:0]          skip_cyc;

    assign op        = bbu_pkg::bbu_op_type'(cmd.op);
    assign sel_flag  = status_flag_register[cmd.bit_sel];
    assign rd_bit    = opr.rd_val[cmd.bit_sel];
    assign io_bit    = opr.io_val[cmd.bit_sel];
    assign diff      = opr.rd_val - opr.imm;
    assign bit_mask  = 8'h01 << cmd.bit_sel;
    assign br_target = pc + 16'($signed(offs)) + bbu_pkg::BBU_PC_STEP; // RULE24
    assign skip_step = cmd.two_word ? bbu_pkg::BBU_PC_SKIP2
                                    : bbu_pkg::BBU_PC_SKIP1;
    assign skip_cyc  = cmd.two_word ? bbu_pkg::BBU_CYC_SKIP2
                                    : bbu_pkg::BBU_CYC_SKIP1; // RULE23

    always_comb begin
        next_pc   = pc + bbu_pkg::BBU_PC_STEP;
        next_status_flag_register = status_flag_register;
        next_rd   = opr.rd_val;
        next_io   = opr.io_val;
        need      = bbu_pkg::BBU_CYC_ONE;
        cond      = 1'b0;
        rot       = 8'h00;
        case (op)
            bbu_pkg::pointer_jump: begin
                next_pc = ptr; // RULE1
                need    = bbu_pkg::BBU_CYC_PJUMP;
            end
            bbu_pkg::pointer_call: begin
                next_pc = ptr; // RULE2
                need    = bbu_pkg::BBU_CYC_PCALL;
            end
            bbu_pkg::compare_skip_equal,
            bbu_pkg::skip_reg_bit_clear,
            bbu_pkg::skip_reg_bit_set,
            bbu_pkg::skip_io_bit_clear,
            bbu_pkg::skip_io_bit_set: begin
                case (op)
                    bbu_pkg::compare_skip_equal:
                        cond = opr.rd_val == opr.rr_val; // RULE3
                    bbu_pkg::skip_reg_bit_clear: cond = !rd_bit; // RULE5
                    bbu_pkg::skip_reg_bit_set:   cond = rd_bit; // RULE6
                    bbu_pkg::skip_io_bit_clear:  cond = !io_bit; // RULE7
                    default:                     cond = io_bit; // RULE8
                endcase
                if (cond) begin
                    next_pc = pc + skip_step; // RULE23
                    need    = skip_cyc;
                end
            end
            bbu_pkg::compare_immediate: begin
                next_status_flag_register[bbu_pkg::BBU_FLAG_H] = // RULE4
                    (!opr.rd_val[3] && opr.imm[3]) ||
                    (opr.imm[3] && diff[3]) || (diff[3] && !opr.rd_val[3]);
                next_status_flag_register[bbu_pkg::BBU_FLAG_V] =
                    (opr.rd_val[7] && !opr.imm[7] && !diff[7]) ||
                    (!opr.rd_val[7] && opr.imm[7] && diff[7]);
                next_status_flag_register[bbu_pkg::BBU_FLAG_C] =
                    (!opr.rd_val[7] && opr.imm[7]) ||
                    (opr.imm[7] && diff[7]) || (diff[7] && !opr.rd_val[7]);
                next_status_flag_register[bbu_pkg::BBU_FLAG_N] = diff[7];
                next_status_flag_register[bbu_pkg::BBU_FLAG_Z] = diff == 8'h00;
                next_status_flag_register[bbu_pkg::BBU_FLAG_S] =
                    diff[7] ^ next_status_flag_register[bbu_pkg::BBU_FLAG_V];
            end
            bbu_pkg::branch_flag_set,
            bbu_pkg::branch_flag_clear,
            bbu_pkg::branch_signed_ge,
            bbu_pkg::branch_signed_lt,
            bbu_pkg::branch_halfcarry_set,
            bbu_pkg::branch_halfcarry_clear,
            bbu_pkg::branch_overflow_set,
            bbu_pkg::branch_overflow_clear,
            bbu_pkg::branch_irq_enabled,
            bbu_pkg::branch_irq_disabled: begin
                case (op)
                    bbu_pkg::branch_flag_set:   cond = sel_flag; // RULE9
                    bbu_pkg::branch_flag_clear: cond = !sel_flag; // RULE10
                    bbu_pkg::branch_signed_ge: // RULE11
                        cond = !(status_flag_register[bbu_pkg::BBU_FLAG_N] ^
                                 status_flag_register[bbu_pkg::BBU_FLAG_V]);
                    bbu_pkg::branch_signed_lt: // RULE12
                        cond = status_flag_register[bbu_pkg::BBU_FLAG_N] ^
                               status_flag_register[bbu_pkg::BBU_FLAG_V];
                    bbu_pkg::branch_halfcarry_set: // RULE13
                        cond = status_flag_register[bbu_pkg::BBU_FLAG_H];
                    bbu_pkg::branch_halfcarry_clear: // RULE13
                        cond = !status_flag_register[bbu_pkg::BBU_FLAG_H];
                    bbu_pkg::branch_overflow_set: // RULE14
                        cond = status_flag_register[bbu_pkg::BBU_FLAG_V];
                    bbu_pkg::branch_overflow_clear: // RULE14
                        cond = !status_flag_register[bbu_pkg::BBU_FLAG_V];
                    bbu_pkg::branch_irq_enabled: // RULE15
                        cond = status_flag_register[bbu_pkg::BBU_FLAG_I];
                    default: // RULE15
                        cond = !status_flag_register[bbu_pkg::BBU_FLAG_I];
                endcase
                if (cond) begin
                    next_pc = br_target; // RULE9
                    need    = bbu_pkg::BBU_CYC_BR_TAKEN;
                end
            end
            bbu_pkg::io_bit_set: begin
                next_io = opr.io_val | bit_mask; // RULE16
                need    = bbu_pkg::BBU_CYC_IOBIT;
            end
            bbu_pkg::io_bit_clear: begin
                next_io = opr.io_val & ~bit_mask; // RULE17
                need    = bbu_pkg::BBU_CYC_IOBIT;
            end
            bbu_pkg::rotate_left_carry,
            bbu_pkg::rotate_right_carry: begin
                if (op == bbu_pkg::rotate_left_carry) begin
                    rot = {opr.rd_val[6:0], status_flag_register[bbu_pkg::BBU_FLAG_C]}; // RULE18
                    next_status_flag_register[bbu_pkg::BBU_FLAG_C] = opr.rd_val[7];
                end else begin
                    rot = {status_flag_register[bbu_pkg::BBU_FLAG_C], opr.rd_val[7:1]}; // RULE19
                    next_status_flag_register[bbu_pkg::BBU_FLAG_C] = opr.rd_val[0];
                end
                next_rd                        = rot;
                next_status_flag_register[bbu_pkg::BBU_FLAG_Z] = rot == 8'h00;
                next_status_flag_register[bbu_pkg::BBU_FLAG_N] = rot[7];
                next_status_flag_register[bbu_pkg::BBU_FLAG_V] =
                    rot[7] ^ next_status_flag_register[bbu_pkg::BBU_FLAG_C];
                next_status_flag_register[bbu_pkg::BBU_FLAG_S] =
                    rot[7] ^ next_status_flag_register[bbu_pkg::BBU_FLAG_V];
            end
            bbu_pkg::bit_to_transfer_flag:
                next_status_flag_register[bbu_pkg::BBU_FLAG_T] = rd_bit; // RULE20
            bbu_pkg::transfer_flag_to_bit:
                next_rd[cmd.bit_sel] = status_flag_register[bbu_pkg::BBU_FLAG_T]; // RULE21
            bbu_pkg::halfcarry_flag_set:
                next_status_flag_register[bbu_pkg::BBU_FLAG_H] = 1'b1; // RULE22
            bbu_pkg::halfcarry_flag_clear:
                next_status_flag_register[bbu_pkg::BBU_FLAG_H] = 1'b0; // RULE22
            bbu_pkg::flag_set:
                next_status_flag_register[cmd.bit_sel] = 1'b1; // RULE22
            bbu_pkg::flag_clear:
                next_status_flag_register[cmd.bit_sel] = 1'b0; // RULE22
            default: begin
                next_pc = pc + bbu_pkg::BBU_PC_STEP;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencing: busy stands for exactly the instruction's cycle count.

    logic commit;

    assign commit = busy && (cnt + 3'h1) == need;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy   <= 1'b0;
            cnt    <= 3'h0;
            cycles <= 3'h0;
        end else if (start) begin
            busy <= 1'b1;
            cnt  <= 3'h0;
        end else if (commit) begin
            busy   <= 1'b0;
            cycles <= need; // RULE23
        end else if (busy) begin
            cnt <= cnt + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers; writes are refused while busy.

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd  <= '0;
            opr  <= '0;
            ptr  <= 16'h0000;
            offs <= '0;
        end else if (wr_ok) begin
            case (wr_addr)
                bbu_pkg::BBU_CTRL_OFF:    cmd  <= hwdata;
                bbu_pkg::BBU_OPERAND_OFF: opr  <= hwdata;
                bbu_pkg::BBU_POINTER_OFF: ptr  <= hwdata[15:0];
                bbu_pkg::BBU_OFFSET_OFF:  offs <= hwdata[OFFSET_W-1:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc       <= bbu_pkg::BBU_PC_RST;
            status_flag_register     <= bbu_pkg::BBU_FLAGS_RST;
            rd_res   <= 8'h00;
            io_res   <= 8'h00;
            ret_addr <= 16'h0000;
        end else if (commit) begin
            pc     <= next_pc;
            status_flag_register   <= next_status_flag_register;
            rd_res <= next_rd;
            io_res <= next_io;
            if (op == bbu_pkg::pointer_call) begin
                ret_addr <= pc + bbu_pkg::BBU_PC_STEP; // RULE2
            end
        end else if (wr_ok && wr_addr == bbu_pkg::BBU_PC_OFF) begin
            pc <= hwdata[15:0];
        end else if (wr_ok && wr_addr == bbu_pkg::BBU_FLAGS_OFF) begin
            status_flag_register <= hwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic start_q;
    logic [4:0] op_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_q <= 1'b0;
            op_q    <= 5'h00;
        end else begin
            start_q <= start;
            op_q    <= hwdata[4:0];
        end
    end

    AST_PJUMP_TIME: assert property ( // RULE1
        start_q && op_q == 5'(bbu_pkg::pointer_jump) |->
            busy[*2] ##1 (!busy && pc == ptr && status_flag_register == $past(status_flag_register)))
        else $error("pointer jump timing or target wrong");

    AST_PCALL_TIME: assert property ( // RULE2
        start_q && op_q == 5'(bbu_pkg::pointer_call) |->
            busy[*3] ##1 (!busy && pc == ptr &&
            ret_addr == $past(pc) + 16'h0001))
        else $error("pointer call timing or target wrong");

    AST_CMPI_ZERO: assert property ( // RULE4
        start_q && op_q == 5'(bbu_pkg::compare_immediate) |->
            busy ##1 (!busy && status_flag_register[1] == (opr.rd_val == opr.imm)))
        else $error("compare immediate zero flag wrong");

    AST_SKIP_NONE: assert property ( // RULE23
        start_q && op_q == 5'(bbu_pkg::skip_reg_bit_set) && !rd_bit |->
            busy ##1 (!busy && pc == $past(pc) + 16'h0001))
        else $error("skip not taken costs other than one cycle");

    AST_SKIP_TWO: assert property ( // RULE3
        start_q && op_q == 5'(bbu_pkg::compare_skip_equal) &&
        opr.rd_val == opr.rr_val && cmd.two_word |->
            busy[*3] ##1 (!busy && pc == $past(pc) + 16'h0003))
        else $error("two-word skip wrong");

    AST_BR_TAKEN: assert property ( // RULE9
        start_q && busy && op_q == 5'(bbu_pkg::branch_flag_set) && sel_flag |->
            busy[*2] ##1 (!busy &&
            pc == $past(pc) + 16'($signed(offs)) + 16'h0001))
        else $error("taken branch wrong");

    AST_ROTL_CARRY: assert property ( // RULE18
        start_q && op_q == 5'(bbu_pkg::rotate_left_carry) |->
            ##1 (status_flag_register[0] == opr.rd_val[7] && rd_res[0] == $past(status_flag_register[0])))
        else $error("rotate left carry wrong");

    AST_IO_SET: assert property ( // RULE16
        start_q && op_q == 5'(bbu_pkg::io_bit_set) |->
            busy[*2] ##1 io_res[cmd.bit_sel] && status_flag_register == $past(status_flag_register))
        else $error("io bit set wrong");

    AST_BIT_STORE_T: assert property ( // RULE20
        start_q && op_q == 5'(bbu_pkg::bit_to_transfer_flag) |->
            ##1 (status_flag_register[6] == rd_bit &&
            status_flag_register[5:0] == $past(status_flag_register[5:0]) && status_flag_register[7] == $past(status_flag_register[7])))
        else $error("bit store wrong");

    COV_BRANCH: cover property (commit && op == bbu_pkg::branch_signed_lt);
    COV_SKIP3:  cover property (commit && need == bbu_pkg::BBU_CYC_SKIP2);
    COV_CALL:   cover property (commit && op == bbu_pkg::pointer_call);
    COV_REFUSE: cover property (wr_pend && busy);

endmodule : bbu_unit

// [test/bbu_core_model.sv]
// Core-side bus master model for the branch and bit unit.
// Assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/10ps
module bbu_core_model (
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [31:0] hwdata,
    output logic             hung
);
    initial begin
        {hsel, haddr, htrans, hwrite, hwdata, hung} = '0;
    end
    // Waits for hready at a rising edge and gives up after 64 edges.
    task automatic hw();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        if (hready !== 1'b1) hung <= 1'b1;
    endtask : hw
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hw();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        hw();
        q = hrdata;
    endtask : xfer
endmodule : bbu_core_model

// [test/test_bbu_unit.sv]
// Bench for the branch and bit unit, driven over its register bus.
// Assumes bbu_core_model as the only master and hready from hreadyout.
`timescale 1ns/10ps
module test_bbu_unit;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        hung;
    logic [31:0] q;
    int          n_errors;
    int          n_checks;
    int          i;
    logic [7:0]  bf [10];
    logic [9:0]  tk;

    bbu_unit #(.OFFSET_W(7)) i_bbu_unit (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
    bbu_core_model i_bbu_core_model (.hclk(hclk), .hready(hreadyout),
        .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hwdata(hwdata), .hung(hung));

    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    task automatic wrap_up();
        $display("Counts: %0d checks, %0d mismatches", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    always @(posedge hung) begin
        n_errors++;
        wrap_up();
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h, expected %h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        i_bbu_core_model.xfer(1'b1, a, d, x);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        i_bbu_core_model.xfer(1'b0, a, 32'h0, q);
    endtask : rd
    // Loads operands, starts one instruction, polls busy, checks results.
    task automatic t(input int op, input int s, input logic [7:0] f,
        input logic [31:0] o, input logic [15:0] pe, input logic [7:0] fe,
        input int ce, input logic [16:0] re);
        int n;
        wr(bbu_pkg::BBU_OPERAND_OFF, o);
        wr(bbu_pkg::BBU_FLAGS_OFF, {24'h0, f});
        wr(bbu_pkg::BBU_PC_OFF, 32'h40);
        wr(bbu_pkg::BBU_CTRL_OFF,
           {1'b1, 18'h0, 1'(s >> 3), 1'b0, 3'(s), 3'h0, 5'(op)});
        if (op == 1) wr(bbu_pkg::BBU_PC_OFF, 32'h7777);
        n = 0;
        do begin
            rd(bbu_pkg::BBU_RESULT_OFF);
            n++;
        end while (q[16] !== 1'b0 && n < 20);
        if (q[16] !== 1'b0) begin
            n_errors++;
            wrap_up();
        end
        chk({29'h0, q[19:17]}, 32'(ce));
        if (re[16]) chk({16'h0, q[15:0]}, {16'h0, re[15:0]});
        rd(bbu_pkg::BBU_PC_OFF);
        chk(q, {16'h0, pe});
        rd(bbu_pkg::BBU_FLAGS_OFF);
        chk(q, {24'h0, fe});
        $display("Test of op %0d done", op);
    endtask : t
    task automatic br(input int k);
        t(8 + k, 1, bf[k], 32'h0, tk[k] ? 16'h3F : 16'h41, bf[k],
          tk[k] ? 2 : 1, 17'h0);
    endtask : br

    initial begin
        hresetn = 1'b0;
        n_errors = 0;
        n_checks = 0;
        bf = '{8'h02, 8'h02, 8'h0C, 8'h04, 8'h20, 8'h20, 8'h00, 8'h00,
               8'h80, 8'h80};
        tk = 10'b0110011101;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(bbu_pkg::BBU_PC_OFF);
        chk(q, 32'h0);
        rd(8'h20);
        chk(q, 32'h0);
        wr(bbu_pkg::BBU_POINTER_OFF, 32'h1234);
        wr(bbu_pkg::BBU_OFFSET_OFF, 32'h7E);
        t(0, 0, 8'hA5, 32'h0, 16'h1234, 8'hA5, 2, 17'h0);
        t(1, 0, 8'h5A, 32'h0, 16'h1234, 8'h5A, 3, 17'h0);
        rd(bbu_pkg::BBU_RETURN_OFF);
        chk(q, 32'h41);
        t(2, 8, 8'h00, 32'h5555, 16'h43, 8'h00, 3, 17'h0);
        t(2, 0, 8'h00, 32'h5555, 16'h42, 8'h00, 2, 17'h0);
        t(2, 0, 8'h00, 32'h5554, 16'h41, 8'h00, 1, 17'h0);
        t(3, 0, 8'hC0, 32'h20000010, 16'h41, 8'hD5, 1, 17'h0);
        t(4, 3, 8'h00, 32'h8, 16'h41, 8'h00, 1, 17'h0);
        t(5, 3, 8'h00, 32'h8, 16'h42, 8'h00, 2, 17'h0);
        t(6, 0, 8'h00, 32'h10000, 16'h41, 8'h00, 1, 17'h0);
        t(7, 0, 8'h00, 32'h10000, 16'h42, 8'h00, 2, 17'h0);
        for (i = 0; i < 5; i++) br(i);
        for (i = 5; i < 10; i++) br(i);
        t(18, 5, 8'h3C, 32'h0, 16'h41, 8'h3C, 2, 17'h12000);
        t(19, 5, 8'h3C, 32'hFF0000, 16'h41, 8'h3C, 2, 17'h1DF00);
        t(20, 0, 8'h01, 32'h80, 16'h41, 8'h19, 1, 17'h10001);
        t(21, 0, 8'h00, 32'h01, 16'h41, 8'h1B, 1, 17'h10000);
        t(22, 2, 8'hFF, 32'hFB, 16'h41, 8'hBF, 1, 17'h0);
        t(23, 7, 8'h40, 32'h0, 16'h41, 8'h40, 1, 17'h10080);
        t(24, 0, 8'h00, 32'h0, 16'h41, 8'h20, 1, 17'h0);
        t(25, 0, 8'hFF, 32'h0, 16'h41, 8'hDF, 1, 17'h0);
        t(26, 1, 8'h00, 32'h0, 16'h41, 8'h02, 1, 17'h0);
        t(27, 7, 8'hFF, 32'h0, 16'h41, 8'h7F, 1, 17'h0);
        chk({31'h0, hresp}, 32'h0);
        chk({31'h0, hreadyout}, 32'h1);
        wrap_up();
    end
endmodule : test_bbu_unit
